/* File: sim/rg_setpoint_ramp_tb.sv */
// Purpose: self-checking bench for the setpoint ramp generator
// Assumes: 1 ms sample period, 0.01 % units, 2^-16 fraction
// Notes:   rise 0.1 s gives 100 units a tick, fall 0.2 s gives 50
`timescale 1ns/10ps
`default_nettype none
module rg_setpoint_ramp_tb
  import rg_pkg::*;
;
  logic                    clk;
  logic                    rst_b;
  logic                    fire;
  logic signed [OUT_W-1:0] level;
  logic                    sampleTick;
  logic signed [OUT_W-1:0] targetIn;
  logic                    idle;
  rg_cfg_t                 cfg;
  logic signed [OUT_W-1:0] rampOut;
  logic                    slewing;
  logic signed [OUT_W-1:0] first;
  int                      errTotal;
  int                      checks;

  rg_tick_source u_src (
    .clk        (clk),
    .rst_b      (rst_b),
    .fire       (fire),
    .level      (level),
    .sampleTick (sampleTick),
    .targetIn   (targetIn),
    .idle       (idle)
  );

  rg_setpoint_ramp #(.SAMPLE_PERIOD_US(1000)) u_dut (
    .clk        (clk),
    .rst_b      (rst_b),
    .sampleTick (sampleTick),
    .cfg        (cfg),
    .targetIn   (targetIn),
    .rampOut    (rampOut),
    .slewing    (slewing)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // waits on the model handshake, bounded so a hang cannot stall us
  task automatic tick(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      fire = 1'b1;
      @(negedge clk);
      fire = 1'b0;
      k = 0;
      while (idle !== 1'b1 && k < 200) begin
        @(negedge clk);
        k++;
      end
      if (k >= 200) errTotal++;
      repeat (2) @(negedge clk);
    end
  endtask

  task automatic load(input logic [15:0] v);
    cfg.restoreLevel = v;
    cfg.extReset = 1'b1;
    repeat (3) @(negedge clk);
    cfg.extReset = 1'b0;
    @(negedge clk);
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // whole run is about 1950 cycles, this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    final_report();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    errTotal = 0;
    checks = 0;
    rst_b = 1'b0;
    fire = 1'b0;
    level = 16'h0000;
    cfg = '0;
    cfg.fallTime = 13'h0002;
    cfg.activity_threshold = 16'h0032;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk("out after reset", 16'h0000, rampOut);
    chk("flag after reset", 16'h0000, {15'h0000, slewing});
    done("reset");
    // rise time 0 is clamped up to the 0.1 s minimum
    level = 16'h015E;
    tick(1);
    chk("rise step", 16'h0064, rampOut);
    chk("flag active", 16'h0001, {15'h0000, slewing});
    tick(3);
    chk("no overshoot", 16'h015E, rampOut);
    chk("flag settled", 16'h0000, {15'h0000, slewing});
    done("rise");
    cfg.hold = 1'b1;
    level = 16'h0000;
    tick(1);
    chk("held", 16'h015E, rampOut);
    cfg.restoreLevel = 16'h03E8;
    cfg.extReset = 1'b1;
    repeat (3) @(negedge clk);
    chk("reset beats hold", 16'h03E8, rampOut);
    tick(1);
    chk("forced restore", 16'h03E8, rampOut);
    cfg.restoreLevel = 16'h8000;
    repeat (3) @(negedge clk);
    chk("restore clamp", LEVEL_MIN, rampOut);
    cfg.restoreLevel = 16'h015E;
    repeat (3) @(negedge clk);
    cfg.extReset = 1'b0;
    cfg.hold = 1'b0;
    @(negedge clk);
    done("hold");
    tick(1);
    chk("fall step", 16'h012C, rampOut);
    done("fall");
    load(16'h0000);
    cfg.invert = 1'b1;
    level = 16'h00C8;
    tick(1);
    chk("inverted step", 16'hFF9C, rampOut);
    tick(2);
    chk("inverted end", 16'hFF38, rampOut);
    cfg.invert = 1'b0;
    done("invert");
    load(16'h0000);
    cfg.driveEnable = 1'b1;
    cfg.floorSpeed = 16'h01F4;
    level = 16'h0064;
    tick(6);
    chk("floor target", 16'h01F4, rampOut);
    done("floor");
    cfg.autoReset = 1'b1;
    cfg.restoreLevel = 16'h00FA;
    cfg.driveEnable = 1'b0;
    repeat (3) @(negedge clk);
    chk("no reset on disable", 16'h01F4, rampOut);
    cfg.driveEnable = 1'b1;
    repeat (3) @(negedge clk);
    chk("reset on enable", 16'h00FA, rampOut);
    cfg.autoReset = 1'b0;
    cfg.driveEnable = 1'b0;
    cfg.floorSpeed = 16'h0000;
    done("rearm");
    load(16'h0000);
    cfg.jogActive = 1'b1;
    cfg.jogSetpoint = 16'h0096;
    level = 16'h015E;
    tick(1);
    chk("jog boundary flag", 16'h0000, {15'h0000, slewing});
    tick(2);
    chk("jog target", 16'h0096, rampOut);
    cfg.jogActive = 1'b0;
    done("jog");
    load(16'h0000);
    cfg.sCurve = 14'h07D0;
    level = 16'h03E8;
    tick(1);
    first = rampOut;
    chk("soft start", 16'h0001,
        {15'h0000, (first > 0) && (first < 16'sh0064)});
    tick(3);
    chk("stretched ramp", 16'h0001,
        {15'h0000, (rampOut > first) && (rampOut <= 16'sh00EC)});
    done("scurve");
    final_report();
  end
endmodule // rg_setpoint_ramp_tb
`default_nettype wire

/* File: sim/rg_tick_source.sv */
// Purpose: upstream model that issues sample ticks and passes the bench level through as the target
// Assumes: fire comes from the bench, driven at the falling edge
// Notes:   ticks spaced past the step latency, closer ones would be lost
`timescale 1ns/10ps
`default_nettype none
module rg_tick_source
  import rg_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    fire,
  input  wire logic signed [OUT_W-1:0] level,
  output logic                         sampleTick,
  output logic signed [OUT_W-1:0]      targetIn,
  output logic                         idle
);
  logic [6:0] gap;

  assign idle = (gap == 7'h00);
  assign targetIn = level;

  // ----------------------------------------------------------------
  // one tick per request, then a quiet gap
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gap <= 7'h00;
      sampleTick <= 1'b0;
    end else begin
      sampleTick <= fire && idle;
      if (fire && idle) begin
        gap <= 7'h50;
      end else if (!idle) begin
        gap <= gap - 7'h01;
      end
    end
  end
endmodule // rg_tick_source
`default_nettype wire

/* File: verilog/rg_divider.sv */
// Purpose: serial restoring divider for the per-tick ramp step
// Assumes: start is ignored while busy; den of zero gives all ones
// Notes:   one quotient bit per clock
`timescale 1ns/10ps
`default_nettype none
module rg_divider #(
  parameter int NW = 48,
  parameter int DW = 32
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  output logic               done,
  output logic [NW-1:0]      quo
);
  typedef struct packed {
    logic [DW:0]           rem;
    logic [NW-1:0]         q;
    logic [DW-1:0]         d;
    logic [$clog2(NW):0]   cnt;
    logic                  busy;
    logic                  done;
  } rg_div_t;

  rg_div_t s;
  rg_div_t next_s;
  logic [DW:0] sh;

  always_comb begin
    next_s = s;
    sh = '0;
    next_s.done = 1'b0;
    if (start && !s.busy) begin
      next_s.rem = '0;
      next_s.q = num;
      next_s.d = den;
      next_s.cnt = ($clog2(NW)+1)'(NW);
      next_s.busy = 1'b1;
    end else if (s.busy) begin
      sh = {s.rem[DW-1:0], s.q[NW-1]};
      next_s.q = {s.q[NW-2:0], 1'b0};
      if (sh >= {1'b0, s.d}) begin
        next_s.rem = sh - {1'b0, s.d};
        next_s.q[0] = 1'b1;
      end else begin
        next_s.rem = sh;
      end
      next_s.cnt = s.cnt - 1'b1;
      if (s.cnt == 1) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign quo  = s.q;
endmodule // rg_divider
`default_nettype wire

/* File: verilog/rg_pkg.sv */
// Purpose: shared constants and carriers for the setpoint ramp generator
// Assumes: levels in 0.01 % units, times in 0.1 s units
// Notes:   fixed point ramp state carries FRAC_W fraction bits
package rg_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int OUT_W  = 16;
  localparam int FRAC_W = 16;
  localparam int ACC_W  = 34;
  localparam int STEP_W = 32;
  localparam int NUM_W  = 48;
  localparam int DEN_W  = 32;
  localparam int TIME_W = 13;
  localparam int SC_W   = 14;

  // ----------------------------------------------------------------
  // levels and timing
  // ----------------------------------------------------------------
  // +-300.00 % restore span
  localparam logic signed [OUT_W-1:0] LEVEL_MAX = 16'sh7530;
  localparam logic signed [OUT_W-1:0] LEVEL_MIN = -16'sh7530;
  // 0.1 s .. 600.0 s
  localparam logic [TIME_W-1:0] TIME_MIN_DS = 13'h0001;
  localparam logic [TIME_W-1:0] TIME_MAX_DS = 13'h1770;
  // s-curve 0.00 .. 100.00 %
  localparam logic [SC_W-1:0]   SCURVE_MAX  = 14'h2710;
  // ramp time x (1 + 3.5 s/100), doubled to stay integer
  localparam logic [16:0]       SC_BASE     = 17'h0_4E20;
  localparam logic [3:0]        SC_MUL      = 4'h7;
  // 100 % per second scale: 10000 / (0.1 s) / 2 / 1e6 us
  localparam logic [15:0]       STEP_SCALE  = 16'h07D0;
  localparam int                SAMPLE_US   = 1000;
  // jerk: dv = stepMax * (DV_BIAS - s) >> DV_SHIFT
  localparam logic [SC_W:0]     DV_BIAS     = 15'h2711;
  localparam int                DV_SHIFT    = 14;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RG_IDLE = 3'b001,
    RG_DIV  = 3'b010,
    RG_STEP = 3'b100
  } rg_phase_t;

  typedef struct packed {
    logic [TIME_W-1:0]       riseTime;
    logic [TIME_W-1:0]       fallTime;
    logic [SC_W-1:0]         sCurve;
    logic [OUT_W-1:0]        activity_threshold;
    logic signed [OUT_W-1:0] restoreLevel;
    logic [OUT_W-1:0]        floorSpeed;
    logic signed [OUT_W-1:0] jogSetpoint;
    logic                    jogActive;
    logic                    invert;
    logic                    hold;
    logic                    autoReset;
    logic                    extReset;
    logic                    driveEnable;
  } rg_cfg_t;
endpackage

/* File: verilog/rg_setpoint_ramp.sv */
// Purpose: slews a setpoint toward a shaped target on each sample tick
// Assumes: all inputs come from logic on clk; sampleTick is one cycle
// Notes:   a tick that lands while a step is in flight is dropped
//
// Behaviour
// - slewing flag when |out - jog| exceeds threshold
// - rise time sets full-scale accelerating duration
// - fall time sets full-scale decelerating duration
// - ramp time scaled by 1 + 3.5*s/100
// - zero s-curve linear, else soft ends
// - hold freezes output; reset overrides hold
// - invert option negates the target input
// - re-arm option resets ramp on start pulse
// - forced restore holds output at restore level
// - forced or re-arm reset loads clamped restore level
// - enabled drive clamps target magnitude to floor
// - target passes jog block, then ramp
// - re-arm resets on enable, not disable
`timescale 1ns/10ps
`default_nettype none
module rg_setpoint_ramp
  import rg_pkg::*;
#(
  parameter int SAMPLE_PERIOD_US = SAMPLE_US
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    sampleTick,
  input  wire rg_cfg_t                 cfg,
  input  wire logic signed [OUT_W-1:0] targetIn,
  output logic signed [OUT_W-1:0]      rampOut,
  output logic                         slewing
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rg_phase_t               st;
    logic signed [ACC_W-1:0] acc;
    logic [STEP_W-1:0]       vel;
    logic [STEP_W-1:0]       stepMax;
    logic [ACC_W-1:0]        brake;
    logic                    dirNeg;
    logic                    enPrev;
    logic                    slewing;
    logic signed [OUT_W-1:0] out;
  } rg_ramp_t;

  localparam logic [NUM_W-1:0] STEP_NUM =
    (NUM_W'(STEP_SCALE) * NUM_W'(SAMPLE_PERIOD_US)) << FRAC_W;

  rg_ramp_t s;
  rg_ramp_t next_s;

  logic signed [OUT_W-1:0] tgtInv, tgtFl, jogOut, restoreLvl;
  logic [OUT_W-1:0]        tgtMag;
  logic signed [ACC_W-1:0] tgtFx, diff;
  logic [ACC_W-1:0]        mag, mv, brake0;
  logic [STEP_W-1:0]       vel0, v, dv;
  logic [STEP_W+SC_W:0]    dvProd;
  logic [TIME_W-1:0]       timeSel;
  logic [DEN_W-1:0]        den;
  logic signed [OUT_W:0]   outDiff;
  logic [OUT_W:0]          outMag;
  logic                    rise, startPulse, rampReset;
  logic                    divStart, divDone;
  logic [NUM_W-1:0]        quo;

  // ----------------------------------------------------------------
  // target path
  // ----------------------------------------------------------------
  always_comb begin
    tgtInv = cfg.invert ? -targetIn : targetIn;
    tgtMag = tgtInv[OUT_W-1] ? OUT_W'(-tgtInv) : OUT_W'(tgtInv);
    tgtFl = tgtInv;
    if (cfg.driveEnable && tgtMag < cfg.floorSpeed) begin
      tgtFl = tgtInv[OUT_W-1] ? -signed'(cfg.floorSpeed)
                              : signed'(cfg.floorSpeed);
    end
    // jog block sits ahead of the ramp shaper
    jogOut = cfg.jogActive ? cfg.jogSetpoint : tgtFl;
    restoreLvl = cfg.restoreLevel;
    if (cfg.restoreLevel > LEVEL_MAX) restoreLvl = LEVEL_MAX;
    if (cfg.restoreLevel < LEVEL_MIN) restoreLvl = LEVEL_MIN;
  end

  // start pulse: one cycle per enable edge, so disable never resets
  assign startPulse = cfg.driveEnable && !s.enPrev;
  // forced restore does not look at the re-arm option
  assign rampReset = cfg.extReset ||
                     (cfg.autoReset && startPulse);

  // ----------------------------------------------------------------
  // step size
  // ----------------------------------------------------------------
  rg_divider #(
    .NW (NUM_W),
    .DW (DEN_W)
  ) u_div (
    .clk   (clk),
    .rst_b (rst_b),
    .start (divStart),
    .num   (STEP_NUM),
    .den   (den),
    .done  (divDone),
    .quo   (quo)
  );

  always_comb begin
    tgtFx = {{(ACC_W-OUT_W-FRAC_W){jogOut[OUT_W-1]}}, jogOut,
             {FRAC_W{1'b0}}};
    diff = tgtFx - s.acc;
    mag = diff[ACC_W-1] ? ACC_W'(-diff) : ACC_W'(diff);
    // away from zero counts as rising
    rise = (s.acc == '0) || (diff[ACC_W-1] == s.acc[ACC_W-1]);
    timeSel = rise ? cfg.riseTime : cfg.fallTime;
    if (timeSel < TIME_MIN_DS) timeSel = TIME_MIN_DS;
    if (timeSel > TIME_MAX_DS) timeSel = TIME_MAX_DS;
    den = DEN_W'(timeSel) *
          DEN_W'(SC_BASE + 17'(SC_MUL) * 17'(cfg.sCurve));
    dvProd = (STEP_W+SC_W+1)'(s.stepMax) *
             (STEP_W+SC_W+1)'(DV_BIAS - 15'(cfg.sCurve));
    dv = STEP_W'(dvProd >> DV_SHIFT);
    if (dv == '0) dv = STEP_W'(1);
    outDiff = (OUT_W+1)'(s.out) - (OUT_W+1)'(jogOut);
    outMag = outDiff[OUT_W] ? (OUT_W+1)'(-outDiff) : (OUT_W+1)'(outDiff);
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    divStart = 1'b0;
    vel0 = s.vel;
    brake0 = s.brake;
    v = '0;
    mv = '0;
    next_s.enPrev = cfg.driveEnable;
    next_s.slewing = ({1'b0, outMag} >
                      (OUT_W+2)'(cfg.activity_threshold));
    unique case (s.st)
      RG_IDLE: begin
        if (sampleTick && !cfg.hold) begin
          divStart = 1'b1;
          next_s.st = RG_DIV;
        end
      end
      RG_DIV: begin
        if (divDone) begin
          next_s.stepMax = (|quo[NUM_W-1:STEP_W]) ? '1
                                                  : quo[STEP_W-1:0];
          next_s.st = RG_STEP;
        end
      end
      RG_STEP: begin
        next_s.st = RG_IDLE;
        if (diff[ACC_W-1] != s.dirNeg) begin
          vel0 = '0;
          brake0 = '0;
        end
        if (cfg.sCurve == '0) begin
          v = s.stepMax;
          next_s.brake = '0;
        end else if (mag <= brake0) begin
          // braking mirrors the distance spent speeding up
          v = (vel0 > dv) ? vel0 - dv : dv;
          next_s.brake = (brake0 > ACC_W'(v)) ? brake0 - ACC_W'(v) : '0;
        end else begin
          v = (vel0 + dv > s.stepMax) ? s.stepMax : vel0 + dv;
          next_s.brake = brake0 + ACC_W'(v);
        end
        if (v > s.stepMax) v = s.stepMax;
        mv = (ACC_W'(v) > mag) ? mag : ACC_W'(v);
        if (cfg.hold) mv = '0;
        next_s.vel = (mag == '0) ? '0 : v;
        next_s.dirNeg = diff[ACC_W-1];
        next_s.acc = diff[ACC_W-1] ? s.acc - signed'(mv)
                                   : s.acc + signed'(mv);
      end
      default: next_s.st = RG_IDLE;
    endcase
    if (rampReset) begin
      next_s.acc = {{(ACC_W-OUT_W-FRAC_W){restoreLvl[OUT_W-1]}},
                    restoreLvl, {FRAC_W{1'b0}}};
      next_s.vel = '0;
      next_s.brake = '0;
      next_s.st = RG_IDLE;
    end
    next_s.out = next_s.acc[FRAC_W +: OUT_W];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '{st: RG_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign rampOut = s.out;
  assign slewing = s.slewing;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_reset_load;
    rampReset |=> rampOut == $past(restoreLvl);
  endproperty
  a_reset_load: assert property (p_reset_load)
    else $error("reset did not load restore level");

  property p_hold_stable;
    cfg.hold && !rampReset ##1 cfg.hold && !rampReset
      |=> $stable(rampOut);
  endproperty
  a_hold_stable: assert property (p_hold_stable)
    else $error("output moved under hold");

  property p_reset_beats_hold;
    cfg.hold && cfg.extReset |=> rampOut == $past(restoreLvl);
  endproperty
  a_reset_beats_hold: assert property (p_reset_beats_hold)
    else $error("hold overrode reset");

  property p_slew_flag;
    ##1 slewing == ($past(outMag) > (OUT_W+1)'($past(
      cfg.activity_threshold)));
  endproperty
  a_slew_flag: assert property (p_slew_flag)
    else $error("slewing flag wrong");

  property p_enable_rearm;
    cfg.autoReset && $rose(cfg.driveEnable) |-> rampReset;
  endproperty
  a_enable_rearm: assert property (p_enable_rearm)
    else $error("enable edge missed re-arm reset");

  property p_no_reset_disable;
    $fell(cfg.driveEnable) && !cfg.extReset |-> !rampReset;
  endproperty
  a_no_reset_disable: assert property (p_no_reset_disable)
    else $error("reset on disable");

  property p_forced;
    cfg.extReset && !cfg.autoReset [*3] |=>
      rampOut == $past(restoreLvl) && s.st == RG_IDLE;
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced restore not held");

  property p_no_overshoot;
    s.st == RG_STEP && !rampReset |=>
      (diff == '0) || (diff[ACC_W-1] == $past(diff[ACC_W-1]))
      || $changed(jogOut);
  endproperty
  a_no_overshoot: assert property (p_no_overshoot)
    else $error("ramp overshot target");

  property p_linear;
    s.st == RG_STEP && cfg.sCurve == '0 && !rampReset && mag != '0
      |=> s.vel == $past(s.stepMax);
  endproperty
  a_linear: assert property (p_linear)
    else $error("zero s-curve not linear");

  property p_tick_steps;
    s.st == RG_IDLE && sampleTick && !cfg.hold && !rampReset
      |=> ##[1:60] (s.st == RG_STEP || rampReset);
  endproperty
  a_tick_steps: assert property (p_tick_steps)
    else $error("tick produced no step");

  property p_jog_path;
    cfg.jogActive |-> jogOut == cfg.jogSetpoint;
  endproperty
  a_jog_path: assert property (p_jog_path)
    else $error("jog block bypassed");

  property p_invert;
    !cfg.jogActive && !cfg.driveEnable && cfg.invert
      |-> jogOut == -targetIn;
  endproperty
  a_invert: assert property (p_invert)
    else $error("input not negated");

  c_step: cover property (s.st == RG_STEP && mag != '0);
  c_reset_hold: cover property (cfg.hold && cfg.extReset);
  c_reach: cover property (s.st == RG_STEP ##1 diff == '0);
  c_scurve: cover property (s.st == RG_STEP && cfg.sCurve != '0);
endmodule // rg_setpoint_ramp
`default_nettype wire
